// file: afm_pkg.sv
// shared constants and types for the airflow and freeze monitor
package afm_pkg;
	localparam int unsigned CODE_W = 10;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned SAMPLE_RATE_HZ = 20;
	localparam int unsigned SAMPLE_DIV_DEF = CLK_HZ / SAMPLE_RATE_HZ;
	localparam int unsigned CAL_SAMPLES = 100;
	localparam int unsigned HITS_FAULT = 5;
	localparam int unsigned FAULT_SPAN = 100;
	localparam int unsigned HIT_SPAN = FAULT_SPAN / HITS_FAULT;
	localparam int unsigned ACQ_BLOCK = 100;
	localparam logic [6:0] ACQ_HALF = 7'h32;
	localparam logic [CODE_W-1:0] DIFF_THRESH_RST = 10'h046;
	localparam logic [CODE_W-1:0] THRESH_STEP = 10'h001;
	localparam int FREEZE_DEG_C = 4;
	localparam int THAW_DEG_C = 24;
	// codes for the temperature points, higher code is colder
	localparam logic [CODE_W-1:0] FREEZE_CODE_DEF = 10'h13a;
	localparam logic [CODE_W-1:0] THAW_CODE_DEF = 10'h119;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CAL,
		ST_POLL,
		ST_FAULT,
		ST_FREEZE
	} afm_state_e;

	// everything that enters from pins, passed through the synchroniser
	typedef struct packed {
		logic cal_btn;
		logic acq_mode;
		logic check_dis;
		logic [CODE_W-1:0] vib_a;
		logic [CODE_W-1:0] vib_b;
		logic [CODE_W-1:0] temp;
	} afm_pins_s;
endpackage : afm_pkg

// file: afm_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module afm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// elaboration-time refusal of an empty bundle
	if (WIDTH < 1) begin : g_bad_width
		$error("afm_sync needs WIDTH of at least 1");
	end

	// first stage is read only by the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : afm_sync
`default_nettype wire

// file: afm_tick.sv
// divider giving a one-cycle sample enable
`timescale 1ns/10ps
`default_nettype none
module afm_tick #(
	parameter int unsigned DIV = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_reg;

	// elaboration-time refusal of a divider that cannot count
	if (DIV < 1) begin : g_bad_div
		$error("afm_tick needs DIV of at least 1");
	end

	// free-running count, tick on the last value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
			tick <= (cnt_reg == LAST);
		end
	end
endmodule : afm_tick
`default_nettype wire

// file: afm_monitor.sv
// airflow and coil-freeze monitor top
`timescale 1ns/10ps
`default_nettype none
module afm_monitor
	import afm_pkg::*;
#(
	parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_DEF,
	parameter logic [CODE_W-1:0] FREEZE_CODE = FREEZE_CODE_DEF,
	parameter logic [CODE_W-1:0] THAW_CODE = THAW_CODE_DEF
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CAL_BTN,
	input wire logic ACQ_MODE,
	input wire logic CHECK_DISABLE,
	input wire logic [CODE_W-1:0] VIB_A_CODE,
	input wire logic [CODE_W-1:0] VIB_B_CODE,
	input wire logic [CODE_W-1:0] TEMP_CODE,
	output logic CONDENSER_CUTOFF_RELAY,
	output logic FAN_OVERRIDE_RELAY,
	output logic FILTER_DIRTY_ALERT,
	output logic CALIBRATED,
	output logic DIFF_OVER,
	output logic [CODE_W-1:0] DIFF_THRESH,
	output logic [CODE_W-1:0] AIRFLOW_AVG,
	output logic [CODE_W-1:0] AIRFLOW_REF
);
	localparam int unsigned SUM_W = CODE_W + $clog2(CAL_SAMPLES);
	localparam logic [6:0] CAL_LAST = 7'(CAL_SAMPLES - 1);
	localparam logic [4:0] SPAN_LAST = 5'(HIT_SPAN - 1);
	localparam logic [2:0] HIT_LIMIT = 3'(HITS_FAULT);
	localparam logic [6:0] ACQ_LAST = 7'(ACQ_BLOCK - 1);
	localparam logic [SUM_W-1:0] CAL_DIV = SUM_W'(CAL_SAMPLES);

	// elaboration-time refusal of settings the logic cannot serve
	if (SAMPLE_DIV < 1) begin : g_bad_div
		$error("SAMPLE_DIV must be at least 1");
	end
	if (THAW_CODE >= FREEZE_CODE) begin : g_bad_codes
		$error("thaw code must be below freeze code");
	end

	// absolute difference of two unsigned codes
	function automatic logic [CODE_W-1:0] abs_diff(
		input logic [CODE_W-1:0] a,
		input logic [CODE_W-1:0] b
	);
		abs_diff = (a >= b) ? a - b : b - a;
	endfunction : abs_diff

	afm_pins_s pins_raw;
	afm_pins_s pins;
	logic tick;
	logic btn_prev_reg;
	afm_state_e state_reg;
	afm_state_e state_next;
	afm_state_e resume_reg;
	logic [SUM_W-1:0] cal_sum_reg;
	logic [6:0] cal_cnt_reg;
	logic [CODE_W-1:0] ref_reg;
	logic [CODE_W-1:0] avg_reg;
	logic [4:0] run_reg;
	logic [2:0] hit_reg;
	logic [CODE_W-1:0] thresh_reg;
	logic [6:0] blk_cnt_reg;
	logic [6:0] over_cnt_reg;

	// pins are asynchronous to REF_CLK; codes settle slowly between ticks
	assign pins_raw = '{
		cal_btn: CAL_BTN,
		acq_mode: ACQ_MODE,
		check_dis: CHECK_DISABLE,
		vib_a: VIB_A_CODE,
		vib_b: VIB_B_CODE,
		temp: TEMP_CODE
	};

	afm_sync #(
		.WIDTH($bits(afm_pins_s))
	) u_sync (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.d(pins_raw),
		.q(pins)
	);

	afm_tick #(
		.DIV(SAMPLE_DIV)
	) u_tick (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.tick(tick)
	);

	// sample decode
	wire cal_press = pins.cal_btn & ~btn_prev_reg;
	// only a press the state machine accepts clears flags; freeze ignores it
	wire cal_start = (state_next == ST_CAL) & (state_reg != ST_CAL);
	wire [CODE_W-1:0] diff = abs_diff(pins.vib_a, pins.vib_b);
	wire diff_over = diff > thresh_reg;
	wire [CODE_W:0] avg_pair = {1'b0, avg_reg} + {1'b0, diff};
	wire [CODE_W-1:0] avg_next = avg_pair[CODE_W:1];
	wire below_half = avg_next < {1'b0, ref_reg[CODE_W-1:1]};
	wire checks_on = ~pins.check_dis;
	wire too_cold = checks_on & (pins.temp > FREEZE_CODE);
	wire thawed = pins.temp <= THAW_CODE;
	wire polling = (state_reg == ST_POLL) & tick;
	wire span_done = below_half & (run_reg == SPAN_LAST);
	wire [2:0] hit_next = hit_reg + 3'h1;
	wire hit_fault = checks_on & span_done & (hit_next == HIT_LIMIT);
	wire cal_done = (state_reg == ST_CAL) & tick & (cal_cnt_reg == CAL_LAST);
	wire [SUM_W-1:0] cal_total = cal_sum_reg + SUM_W'(diff);
	wire [SUM_W-1:0] cal_mean = cal_total / CAL_DIV;
	wire acq_step = polling & pins.acq_mode;
	wire [6:0] over_total = over_cnt_reg + {6'h00, diff_over};
	wire acq_lower = (over_total < ACQ_HALF) & (thresh_reg != '0);

	// state sequencing; freeze checks happen only on sample ticks
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (cal_press) begin
					state_next = ST_CAL;
				end
			end
			ST_CAL: begin
				if (cal_done) begin
					state_next = ST_POLL;
				end
			end
			ST_POLL: begin
				if (cal_press) begin
					state_next = ST_CAL;
				end else if (tick & too_cold) begin
					state_next = ST_FREEZE;
				end else if (polling & hit_fault) begin
					state_next = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (cal_press) begin
					state_next = ST_CAL;
				end else if (tick & too_cold) begin
					state_next = ST_FREEZE;
				end
			end
			ST_FREEZE: begin
				if (tick & thawed) begin
					state_next = resume_reg;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state, resume point and button edge history
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= ST_IDLE;
			resume_reg <= ST_POLL;
			btn_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			btn_prev_reg <= pins.cal_btn;
			if (state_next == ST_FREEZE && state_reg != ST_FREEZE) begin
				resume_reg <= state_reg;
			end
		end
	end

	// calibration accumulator; restarts on every press the state machine accepts (none in calibration or freeze)
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cal_sum_reg <= '0;
			cal_cnt_reg <= '0;
			ref_reg <= '0;
		end else if (cal_start) begin
			cal_sum_reg <= '0;
			cal_cnt_reg <= '0;
		end else if (state_reg == ST_CAL && tick) begin
			cal_sum_reg <= cal_total;
			cal_cnt_reg <= cal_cnt_reg + 7'h01;
			if (cal_done) begin
				ref_reg <= cal_mean[CODE_W-1:0];
			end
		end
	end

	// running average follows the samples while polling
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			avg_reg <= '0;
		end else if (cal_done) begin
			avg_reg <= cal_mean[CODE_W-1:0];
		end else if (polling) begin
			avg_reg <= avg_next;
		end
	end

	// a hit is twenty low samples in a row; any normal sample restarts
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			run_reg <= '0;
			hit_reg <= '0;
		end else if (state_reg != ST_POLL) begin
			run_reg <= '0;
			hit_reg <= '0;
		end else if (polling & checks_on) begin
			if (!below_half) begin
				run_reg <= '0;
				hit_reg <= '0;
			end else if (span_done) begin
				run_reg <= '0;
				hit_reg <= hit_next;
			end else begin
				run_reg <= run_reg + 5'h01;
			end
		end
	end

	// threshold acquisition in blocks; leaving the mode restores default
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			thresh_reg <= DIFF_THRESH_RST;
			blk_cnt_reg <= '0;
			over_cnt_reg <= '0;
		end else if (!pins.acq_mode) begin
			thresh_reg <= DIFF_THRESH_RST;
			blk_cnt_reg <= '0;
			over_cnt_reg <= '0;
		end else if (acq_step) begin
			if (blk_cnt_reg == ACQ_LAST) begin
				blk_cnt_reg <= '0;
				over_cnt_reg <= '0;
				if (acq_lower) begin
					thresh_reg <= thresh_reg - THRESH_STEP;
				end
			end else begin
				blk_cnt_reg <= blk_cnt_reg + 7'h01;
				over_cnt_reg <= over_total;
			end
		end
	end

	// outputs, all registered; relays follow the freeze state
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			CONDENSER_CUTOFF_RELAY <= 1'b0;
			FAN_OVERRIDE_RELAY <= 1'b0;
			FILTER_DIRTY_ALERT <= 1'b0;
			CALIBRATED <= 1'b0;
			DIFF_OVER <= 1'b0;
		end else begin
			CONDENSER_CUTOFF_RELAY <= (state_next == ST_FREEZE);
			FAN_OVERRIDE_RELAY <= (state_next == ST_FREEZE);
			if (state_next == ST_FAULT && state_reg == ST_POLL) begin
				FILTER_DIRTY_ALERT <= 1'b1;
			end else if (cal_start) begin
				FILTER_DIRTY_ALERT <= 1'b0;
			end
			if (cal_done) begin
				CALIBRATED <= 1'b1;
			end else if (cal_start) begin
				CALIBRATED <= 1'b0;
			end
			if (polling) begin
				DIFF_OVER <= diff_over;
			end
		end
	end

	// mirrors of internal values; one cycle behind the source register
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			DIFF_THRESH <= DIFF_THRESH_RST;
			AIRFLOW_AVG <= '0;
			AIRFLOW_REF <= '0;
		end else begin
			DIFF_THRESH <= thresh_reg;
			AIRFLOW_AVG <= avg_reg;
			AIRFLOW_REF <= ref_reg;
		end
	end
endmodule : afm_monitor
`default_nettype wire

// file: afm_monitor_sva.sv
// assertions on the monitor's pins
`timescale 1ns/10ps
`default_nettype none
module afm_monitor_sva
	import afm_pkg::*;
#(
	parameter logic [CODE_W-1:0] FREEZE_CODE = FREEZE_CODE_DEF,
	parameter logic [CODE_W-1:0] THAW_CODE = THAW_CODE_DEF
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CAL_BTN,
	input wire logic ACQ_MODE,
	input wire logic CHECK_DISABLE,
	input wire logic [CODE_W-1:0] TEMP_CODE,
	input wire logic CONDENSER_CUTOFF_RELAY,
	input wire logic FAN_OVERRIDE_RELAY,
	input wire logic FILTER_DIRTY_ALERT,
	input wire logic CALIBRATED,
	input wire logic DIFF_OVER,
	input wire logic [CODE_W-1:0] DIFF_THRESH,
	input wire logic [CODE_W-1:0] AIRFLOW_REF
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	relays_equal_a:
		assert property (CONDENSER_CUTOFF_RELAY == FAN_OVERRIDE_RELAY)
		else $error("relay outputs differ");
	freeze_entry_a:
		assert property ($rose(CONDENSER_CUTOFF_RELAY) |-> CALIBRATED &&
			$past(TEMP_CODE, 3) > FREEZE_CODE && !$past(CHECK_DISABLE, 3))
		else $error("relays rose without a cold sample");
	thaw_exit_a:
		assert property ($fell(CONDENSER_CUTOFF_RELAY) |->
			$past(TEMP_CODE, 3) <= THAW_CODE)
		else $error("relays fell before thaw");
	alert_set_a:
		assert property ($rose(FILTER_DIRTY_ALERT) |->
			!CONDENSER_CUTOFF_RELAY && !$past(CHECK_DISABLE, 3))
		else $error("alert rose while checks were off");
	alert_clear_a:
		assert property ($fell(FILTER_DIRTY_ALERT) |->
			$past(CAL_BTN, 3) || $past(CAL_BTN, 4))
		else $error("alert cleared without a press");
	thresh_step_a:
		assert property ($changed(DIFF_THRESH) |-> DIFF_THRESH == DIFF_THRESH_RST
			|| DIFF_THRESH == $past(DIFF_THRESH) - THRESH_STEP)
		else $error("threshold moved by a wrong step");
	thresh_acq_a:
		assert property (DIFF_THRESH < $past(DIFF_THRESH) |-> $past(ACQ_MODE, 4))
		else $error("threshold lowered outside acquisition");
	ref_on_cal_a:
		assert property ($changed(AIRFLOW_REF) |->
			CALIBRATED && !$past(CALIBRATED, 2))
		else $error("reference changed away from calibration end");
	diff_poll_a:
		assert property ($changed(DIFF_OVER) |-> CALIBRATED &&
			!$past(CONDENSER_CUTOFF_RELAY) && !$past(FILTER_DIRTY_ALERT))
		else $error("difference flag updated outside polling");
endmodule : afm_monitor_sva

bind afm_monitor afm_monitor_sva #(.FREEZE_CODE(FREEZE_CODE),
	.THAW_CODE(THAW_CODE)) u_afm_monitor_sva (.REF_CLK, .RESETN, .CAL_BTN,
	.ACQ_MODE, .CHECK_DISABLE, .TEMP_CODE, .CONDENSER_CUTOFF_RELAY,
	.FAN_OVERRIDE_RELAY, .FILTER_DIRTY_ALERT, .CALIBRATED, .DIFF_OVER,
	.DIFF_THRESH, .AIRFLOW_REF);
`default_nettype wire

// file: afm_sensor_model.sv
// behavioural sensor front end giving converter codes
`timescale 1ns/10ps
`default_nettype none
module afm_sensor_model
	import afm_pkg::*;
(
	input wire logic clk,
	input wire logic [CODE_W-1:0] airflow_diff,
	input wire logic [CODE_W-1:0] temp_level,
	output logic [CODE_W-1:0] vib_a,
	output logic [CODE_W-1:0] vib_b,
	output logic [CODE_W-1:0] temp
);
	logic [6:0] walk_reg = 7'h00;
	logic [CODE_W-1:0] base;

	// base wanders and the higher channel swaps, so only |a-b| means anything
	assign base = 10'h064 + {3'h0, walk_reg};
	assign vib_a = walk_reg[0] ? base + airflow_diff : base;
	assign vib_b = walk_reg[0] ? base : base + airflow_diff;
	assign temp = temp_level;

	// steps just after the edge, like a converter refreshing its result
	always @(posedge clk) begin
		walk_reg <= walk_reg + 7'h01;
	end
endmodule : afm_sensor_model
`default_nettype wire

// file: afm_monitor_bench.sv
// self-checking bench for the airflow and freeze monitor
`timescale 1ns/10ps
`default_nettype none
module afm_monitor_bench;
	import afm_pkg::*;
	localparam logic [CODE_W-1:0] FRZ = FREEZE_CODE_DEF;
	localparam logic [CODE_W-1:0] THW = THAW_CODE_DEF;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cal_btn = 1'b0;
	logic acq = 1'b0;
	logic chk_dis = 1'b0;
	logic [CODE_W-1:0] diff = '0;
	logic [CODE_W-1:0] temp_req = THW - 10'h014;
	logic [CODE_W-1:0] vib_a, vib_b, temp, thresh, avg, ref_code, d;
	logic relay_c, relay_f, alert, calibrated, diff_over;
	logic [23:0] notes[$];
	logic [23:0] obs, prev_obs;
	logic [31:0] lfsr_state = 32'ha97d;
	int miscompares = 0;
	int samples_checked = 0;

	assign obs = {relay_c, relay_f, alert, diff_over, thresh, ref_code};

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// short sample period keeps the 100-sample counts quick
	afm_monitor #(.SAMPLE_DIV(4)) u_afm_monitor (.REF_CLK(ref_clk),
		.RESETN(rst_n), .CAL_BTN(cal_btn), .ACQ_MODE(acq),
		.CHECK_DISABLE(chk_dis), .VIB_A_CODE(vib_a), .VIB_B_CODE(vib_b),
		.TEMP_CODE(temp), .CONDENSER_CUTOFF_RELAY(relay_c),
		.FAN_OVERRIDE_RELAY(relay_f), .FILTER_DIRTY_ALERT(alert),
		.CALIBRATED(calibrated), .DIFF_OVER(diff_over), .DIFF_THRESH(thresh),
		.AIRFLOW_AVG(avg), .AIRFLOW_REF(ref_code));
	afm_sensor_model u_afm_sensor_model (.clk(ref_clk), .airflow_diff(diff),
		.temp_level(temp_req), .vib_a(vib_a), .vib_b(vib_b), .temp(temp));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic miss(input string msg);
		miscompares++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask : miss

	task automatic cmp_obs(input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) miss($sformatf("outputs %h, expected %h", got, exp));
	endtask : cmp_obs

	task automatic cmp_code(input logic [CODE_W-1:0] exp,
		input logic [CODE_W-1:0] got);
		samples_checked++;
		if (got !== exp) miss($sformatf("code %h, expected %h", got, exp));
	endtask : cmp_code

	task automatic cmp_flag(input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) miss($sformatf("flag %b, expected %b", got, exp));
	endtask : cmp_flag

	// flags are relay, relay, alert, difference flag; reference is always d
	task automatic note(input logic [3:0] f, input logic [CODE_W-1:0] t);
		notes.push_back({f, t, d});
	endtask : note

	task automatic press();
		@(posedge ref_clk);
		cal_btn <= 1'b1;
		repeat (8) @(posedge ref_clk);
		cal_btn <= 1'b0;
	endtask : press

	// waits bounded for the notes to be used up; leftovers mean a miss
	task automatic drain(input int n, input string name);
		int i;
		for (i = 0; i < n && notes.size() > 0; i++) begin
			@(posedge ref_clk);
		end
		repeat (2) @(posedge ref_clk);
		if (notes.size() > 0) begin
			miss("expected change missing");
			notes.delete();
		end
		$display("test %s done", name);
	endtask : drain

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// every change on the watched outputs must match the oldest note
	always @(negedge ref_clk) begin
		if (rst_n && obs !== prev_obs) begin
			if (notes.size() == 0) miss("unexpected output change");
			else cmp_obs(notes.pop_front(), obs);
		end
		prev_obs = obs;
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		lfsr_state = lfsr(lfsr_state);
		d = 10'(100 + lfsr_state % 400);
		@(posedge ref_clk);
		cmp_obs({4'h0, DIFF_THRESH_RST, 10'h000}, obs);
		diff <= d;
		note(4'h0, DIFF_THRESH_RST);
		note(4'h1, DIFF_THRESH_RST);
		press();
		drain(700, "calibrate");
		@(negedge ref_clk);
		cmp_code(d, avg);
		cmp_flag(1'b1, calibrated);
		@(posedge ref_clk);
		diff <= '0;
		note(4'h0, DIFF_THRESH_RST);
		note(4'h2, DIFF_THRESH_RST);
		drain(600, "airflow fault");
		@(negedge ref_clk);
		cmp_code(10'h000, avg);
		@(posedge ref_clk);
		// no polling in fault, so restoring airflow moves nothing
		diff <= d;
		repeat (40) @(posedge ref_clk);
		note(4'h0, DIFF_THRESH_RST);
		note(4'h1, DIFF_THRESH_RST);
		press();
		@(negedge ref_clk);
		cmp_flag(1'b0, calibrated);
		@(posedge ref_clk);
		drain(700, "recalibrate");
		@(negedge ref_clk);
		cmp_code(d, avg);
		@(posedge ref_clk);
		temp_req <= FRZ;
		repeat (40) @(posedge ref_clk);
		temp_req <= FRZ + 10'h001;
		note(4'hd, DIFF_THRESH_RST);
		drain(40, "freeze entry");
		// airflow drops while frozen, but only temperature is polled
		diff <= '0;
		temp_req <= THW + 10'h001;
		repeat (40) @(posedge ref_clk);
		diff <= d;
		repeat (4) @(posedge ref_clk);
		temp_req <= THW;
		note(4'h1, DIFF_THRESH_RST);
		drain(40, "thaw");
		chk_dis <= 1'b1;
		acq <= 1'b1;
		diff <= '0;
		temp_req <= FRZ + 10'h001;
		note(4'h0, DIFF_THRESH_RST);
		note(4'h0, DIFF_THRESH_RST - THRESH_STEP);
		drain(700, "acquire");
		acq <= 1'b0;
		note(4'h0, DIFF_THRESH_RST);
		drain(40, "threshold reset");
		// the coil is still cold, so turning checks back on freezes at once
		chk_dis <= 1'b0;
		note(4'hc, DIFF_THRESH_RST);
		drain(40, "checks restored");
		// reset in mid-freeze must drop relays and forget the reference
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		cmp_obs({4'h0, DIFF_THRESH_RST, 10'h000}, obs);
		cmp_code(10'h000, avg);
		cmp_flag(1'b0, calibrated);
		$display("test reset done");
		give_verdict();
	end

	// the run needs about 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		miss("watchdog expired");
		give_verdict();
	end
endmodule : afm_monitor_bench
`default_nettype wire
